// ==== sensor_prog_end.sv ====
`timescale 1ns/1ps
// Purpose: Sensor end of the supply-line programming link.
// Assumes: Host keeps its own sync, telegram and reply-timeout duties.
// Notes:   Both directions use the same bi-phase mark line code.
module sensor_prog_end
  import link_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  supply_link_if.sensor                   link,
  input  wire logic [link_pkg::DATA_W-1:0] angle_in,
  output logic                            prog_mode,
  output logic                            cfg_frozen
);
  import link_pkg::*;

  typedef enum logic [2:0] {APP, SYNC, RX, EXEC, TX} state_e;

  state_e                 state_r;
  logic                   line_r;
  logic [CNT_W-1:0]       cnt_r;
  logic                   half_seen_r;
  logic [4:0]             bits_r;
  logic [FRAME_BITS-1:0]  sh_r;
  logic [DATA_W-1:0]      mem_r [MEM_DEPTH];
  logic [DATA_W-1:0]      shadow_r [MEM_DEPTH];
  logic [FRAME_BITS-1:0]  tx_r;
  logic                   tx_lvl_r;
  logic                   edge_w;
  logic [CMD_W-1:0]       cmd_w;
  logic [ADDR_W-1:0]      addr_w;
  logic [DATA_W-1:0]      arg_w;

  assign edge_w = link.sup_hi ^ line_r;
  assign cmd_w  = sh_r[FRAME_BITS-1 -: CMD_W];
  assign addr_w = sh_r[ADDR_W-1:0];
  assign arg_w  = sh_r[DATA_W-1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= 1'b0;
    end else begin
      line_r <= link.sup_hi;
    end
  end

  // ==========================================================
  // Receive, execute and reply sequencing.
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= APP;
      cnt_r       <= CNT_ZERO;
      half_seen_r <= 1'b0;
      bits_r      <= BITS_ZERO;
      sh_r        <= '0;
      tx_r        <= '0;
    end else begin
      unique case (state_r)
        APP: begin
          // Only a long high level on the supply leaves application mode.
          if (link.sup_hi) begin
            cnt_r <= cnt_r + CNT_ONE;
            if (cnt_r >= CNT_W'(SYNC_CYC)) begin
              state_r <= SYNC;
            end
          end else begin
            cnt_r <= CNT_ZERO;
          end
        end
        SYNC: begin
          // Falling end of the sync pulse starts the first bit.
          if (edge_w) begin
            state_r     <= RX;
            cnt_r       <= CNT_ZERO;
            half_seen_r <= 1'b0;
            bits_r      <= BITS_ZERO;
          end
        end
        RX: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (edge_w) begin
            if (cnt_r < CNT_W'(EDGE_MIN_CYC)) begin
              half_seen_r <= 1'b1;
            end else begin
              // Boundary edge closes the bit; a mid edge makes it a one.
              sh_r        <= {sh_r[FRAME_BITS-2:0], half_seen_r};
              half_seen_r <= 1'b0;
              cnt_r       <= CNT_ZERO;
              bits_r      <= bits_r + 5'h01;
              if (bits_r == 5'(FRAME_BITS - 1)) begin
                state_r <= EXEC;
              end
            end
          end else if (cnt_r > CNT_W'(EDGE_MAX_CYC)) begin
            // A lost boundary drops the telegram and waits for the next one.
            state_r     <= SYNC;
            bits_r      <= BITS_ZERO;
            half_seen_r <= 1'b0;
          end
        end
        EXEC: begin
          unique case (cmd_w)
            CMD_READ:   tx_r <= {RSP_DATA, mem_r[addr_w]};
            CMD_WRITE:  tx_r <= cfg_frozen ? {RSP_ERR, ERR_LOCKED} : {RSP_ACK, arg_w};
            CMD_STORE:  tx_r <= cfg_frozen ? {RSP_ERR, ERR_LOCKED} : {RSP_ACK, arg_w};
            CMD_LOCK:   tx_r <= {RSP_ACK, arg_w};
            CMD_STATUS: tx_r <= {RSP_DATA, DATA_W'(cfg_frozen)};
            CMD_ANGLE:  tx_r <= {RSP_DATA, angle_in};
            default:    tx_r <= {RSP_ERR, ERR_CMD};
          endcase
          state_r <= TX;
          cnt_r   <= CNT_ZERO;
          bits_r  <= BITS_ZERO;
        end
        TX: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (cnt_r == CNT_W'(BIT_CYC - 1)) begin
            cnt_r  <= CNT_ZERO;
            tx_r   <= {tx_r[FRAME_BITS-2:0], 1'b0};
            bits_r <= bits_r + 5'h01;
            if (bits_r == 5'(FRAME_BITS - 1)) begin
              state_r <= SYNC;
              bits_r  <= BITS_ZERO;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Reply line coding on the supply current.
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lvl_r <= 1'b0;
    end else if (state_r == TX) begin
      if (cnt_r == CNT_W'(BIT_CYC - 1)) begin
        tx_lvl_r <= ~tx_lvl_r;
      end else if (cnt_r == CNT_W'(HALF_CYC - 1) && tx_r[FRAME_BITS-1]) begin
        tx_lvl_r <= ~tx_lvl_r;
      end
    end else if (state_r == APP) begin
      // The level is held between replies: forcing it low after a reply with an odd
      // count of ones would put a stray one-cycle edge on the current line.
      tx_lvl_r <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration memory, non-volatile shadow and freeze bit.
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i]    <= DATA_ZERO;
        shadow_r[i] <= DATA_ZERO;
      end
    end else if (state_r == EXEC && !cfg_frozen) begin
      if (cmd_w == CMD_WRITE) begin
        mem_r[sh_r[DATA_W-1 -: ADDR_W]] <= {4'h0, sh_r[7:0]};
      end else if (cmd_w == CMD_STORE) begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
          shadow_r[i] <= mem_r[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_frozen <= 1'b0;
    end else if (state_r == EXEC && cmd_w == CMD_LOCK) begin
      cfg_frozen <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_mode   <= 1'b0;
      link.cur_hi <= 1'b0;
    end else begin
      prog_mode   <= (state_r != APP);
      link.cur_hi <= tx_lvl_r;
    end
  end
endmodule

// ==== link_pkg.sv ====
// Purpose: Shared constants for the supply-line programming link.
// Assumes: One 250 MHz clock at both ends; bit time set by a cycle count.
// Notes:   Telegram is a fixed 16-bit frame: 4-bit command, 12-bit data.
package link_pkg;
  // Bit period in nanoseconds; the cycle counts derive from it.
  localparam int BIT_TIME_NS   = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int HALF_CYC      = BIT_CYC / 2;
  // A bit boundary is accepted in a window of three quarters to 3/2 period.
  localparam int EDGE_MIN_CYC  = (BIT_CYC * 3) / 4;
  localparam int EDGE_MAX_CYC  = (BIT_CYC * 3) / 2;
  // Long sync pulse: supply held high this many bit periods.
  localparam int SYNC_BITS     = 4;
  localparam int SYNC_CYC      = SYNC_BITS * BIT_CYC;
  localparam int CNT_W         = 12;
  localparam int FRAME_BITS    = 16;
  localparam int CMD_W         = 4;
  localparam int DATA_W        = 12;
  localparam int MEM_DEPTH     = 16;
  localparam int ADDR_W        = 4;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 12'h000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 12'h001;
  localparam logic [4:0]        BITS_ZERO = 5'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
  // Commands in the top nibble of a request.
  localparam logic [CMD_W-1:0] CMD_READ   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE  = 4'h2;
  localparam logic [CMD_W-1:0] CMD_STORE  = 4'h3;
  localparam logic [CMD_W-1:0] CMD_LOCK   = 4'h4;
  localparam logic [CMD_W-1:0] CMD_STATUS = 4'h5;
  localparam logic [CMD_W-1:0] CMD_ANGLE  = 4'h6;
  // Reply commands.
  localparam logic [CMD_W-1:0] RSP_DATA   = 4'ha;
  localparam logic [CMD_W-1:0] RSP_ACK    = 4'hb;
  localparam logic [CMD_W-1:0] RSP_ERR    = 4'hc;
  // Error codes carried in a RSP_ERR reply.
  localparam logic [DATA_W-1:0] ERR_LOCKED = 12'h001;
  localparam logic [DATA_W-1:0] ERR_CMD    = 12'h002;
endpackage

// ==== supply_link_if.sv ====
`timescale 1ns/1ps
// Purpose: Carrier between programming host and sensor end.
// Assumes: Supply voltage and current modulation abstracted to logic levels.
// Notes:   sup_hi is the voltage level, cur_hi the current modulation.
interface supply_link_if;
  logic sup_hi;
  logic cur_hi;
  modport host   (output sup_hi, input cur_hi);
  modport sensor (input sup_hi, output cur_hi);
endinterface

// ==== host_prog_end.sv ====
`timescale 1ns/1ps
// Purpose: Programming host end driving the supply line.
// Assumes: User issues one 16-bit request at a time.
// Notes:   Sync pulse precedes every request; the reply is decoded by timing.
module host_prog_end
  import link_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  supply_link_if.host                         link,
  input  wire logic                           req_valid,
  input  wire logic [link_pkg::FRAME_BITS-1:0] req_frame,
  output logic                                req_ready,
  output logic                                rsp_valid,
  output logic [link_pkg::FRAME_BITS-1:0]     rsp_frame,
  output logic                                rsp_ack
);
  import link_pkg::*;

  typedef enum logic [2:0] {IDLE, SYNC, GAP, SEND, WAIT} state_e;

  state_e                state_r;
  logic [CNT_W-1:0]      cnt_r;
  logic [4:0]            bits_r;
  logic [FRAME_BITS-1:0] tx_r;
  logic [FRAME_BITS-1:0] rx_r;
  logic                  lvl_r;
  logic                  cur_r;
  logic                  half_r;
  logic                  edge_w;

  assign edge_w = link.cur_hi ^ cur_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= 1'b0;
    end else begin
      cur_r <= link.cur_hi;
    end
  end

  // ==========================================================
  // Sync pulse, telegram send and reply capture.
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= IDLE;
      cnt_r     <= CNT_ZERO;
      bits_r    <= BITS_ZERO;
      tx_r      <= '0;
      rx_r      <= '0;
      lvl_r     <= 1'b0;
      half_r    <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_frame <= '0;
      rsp_ack   <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_r)
        IDLE: begin
          if (req_valid) begin
            tx_r      <= req_frame;
            req_ready <= 1'b0;
            lvl_r     <= 1'b1;
            cnt_r     <= CNT_ZERO;
            state_r   <= SYNC;
          end
        end
        SYNC: begin
          cnt_r <= cnt_r + CNT_ONE;
          // Held past the sensor threshold so entry is never marginal.
          if (cnt_r == CNT_W'(SYNC_CYC + BIT_CYC)) begin
            lvl_r   <= 1'b0;
            cnt_r   <= CNT_ZERO;
            bits_r  <= BITS_ZERO;
            state_r <= SEND;
          end
        end
        SEND: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (cnt_r == CNT_W'(HALF_CYC - 1) && tx_r[FRAME_BITS-1]) begin
            lvl_r <= ~lvl_r;
          end
          if (cnt_r == CNT_W'(BIT_CYC - 1)) begin
            lvl_r  <= ~lvl_r;
            cnt_r  <= CNT_ZERO;
            tx_r   <= {tx_r[FRAME_BITS-2:0], 1'b0};
            bits_r <= bits_r + 5'h01;
            if (bits_r == 5'(FRAME_BITS - 1)) begin
              bits_r  <= BITS_ZERO;
              half_r  <= 1'b0;
              state_r <= GAP;
            end
          end
        end
        GAP: begin
          // Reply bit timing starts as soon as the request ends; cnt_r is already zero here.
          cnt_r <= CNT_ZERO;
          if (edge_w || cnt_r == CNT_ZERO) begin
            state_r <= WAIT;
          end
        end
        WAIT: begin
          cnt_r <= cnt_r + CNT_ONE;
          if (edge_w) begin
            if (cnt_r < CNT_W'(EDGE_MIN_CYC)) begin
              half_r <= 1'b1;
            end else begin
              rx_r   <= {rx_r[FRAME_BITS-2:0], half_r};
              half_r <= 1'b0;
              cnt_r  <= CNT_ZERO;
              bits_r <= bits_r + 5'h01;
              if (bits_r == 5'(FRAME_BITS - 1)) begin
                rsp_valid <= 1'b1;
                rsp_frame <= {rx_r[FRAME_BITS-2:0], half_r};
                rsp_ack   <= ({rx_r[FRAME_BITS-2:0], half_r} >> DATA_W) != FRAME_BITS'(RSP_ERR);
                req_ready <= 1'b1;
                state_r   <= IDLE;
              end
            end
          end else if (cnt_r > CNT_W'(SYNC_CYC * 4)) begin
            rsp_valid <= 1'b1;
            rsp_ack   <= 1'b0;
            req_ready <= 1'b1;
            state_r   <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link.sup_hi <= 1'b0;
    end else begin
      link.sup_hi <= lvl_r;
    end
  end
endmodule

// ==== link_monitor.sv ====
// Purpose: Concurrent checks on the supply link joining host and sensor ends.
// Assumes: One clock; line edge spacing is counted in cycles between changes.
// Notes:   Watches the first link only; the faulted link is judged by the bench.
`timescale 1ns/1ps
module link_monitor
  import link_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sup_hi,
  input wire logic cur_hi,
  input wire logic prog_mode,
  input wire logic cfg_frozen
);
  // ==========================================================================
  // Edge spacing helpers
  logic             sup_q_r;
  logic             cur_q_r;
  logic             sync_seen_r;
  logic [CNT_W-1:0] gap_s_r;
  logic [CNT_W-1:0] gap_c_r;
  wire              chg_s = sup_hi != sup_q_r;
  wire              chg_c = cur_hi != cur_q_r;

  // Gaps start saturated so the first edge after reset is never taken as a bit.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sup_q_r     <= 1'b0;
      cur_q_r     <= 1'b0;
      sync_seen_r <= 1'b0;
      gap_s_r     <= 12'hfff;
      gap_c_r     <= 12'hfff;
    end else begin
      sup_q_r     <= sup_hi;
      cur_q_r     <= cur_hi;
      sync_seen_r <= sync_seen_r | (sup_hi & (gap_s_r > 12'hc8));
      gap_s_r     <= chg_s ? CNT_ONE : (&gap_s_r ? gap_s_r : gap_s_r + CNT_ONE);
      gap_c_r     <= chg_c ? CNT_ONE : (&gap_c_r ? gap_c_r : gap_c_r + CNT_ONE);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_reset_app_mode: assert property ($rose(rst_n) |-> !prog_mode && !cfg_frozen)
    else $error("programming mode or freeze set right after reset");
  a_sync_before_prog: assert property ($rose(prog_mode) |-> sync_seen_r || (sup_hi && gap_s_r > 12'hc8))
    else $error("programming mode entered without a long sync pulse");
  a_prog_mode_held: assert property (prog_mode |=> prog_mode)
    else $error("programming mode dropped without reset");
  a_cur_app_idle: assert property (!prog_mode |-> !cur_hi)
    else $error("current modulated outside programming mode");
  a_reply_bit_timing: assert property ((chg_c && gap_c_r < 12'h096) |->
    (gap_c_r == HALF_CYC || gap_c_r == BIT_CYC))
    else $error("reply edge spacing is neither half nor full bit");
  a_host_bit_timing: assert property ((chg_s && gap_s_r < 12'h096) |->
    (gap_s_r == HALF_CYC || gap_s_r == BIT_CYC))
    else $error("request edge spacing is neither half nor full bit");
  a_freeze_sticky: assert property (cfg_frozen |=> cfg_frozen)
    else $error("freeze bit cleared without reset");
  a_freeze_in_prog: assert property ($rose(cfg_frozen) |-> prog_mode)
    else $error("freeze set outside programming mode");

  c_prog_entry: cover property ($rose(prog_mode));
  c_frozen: cover property ($rose(cfg_frozen));
  c_reply_one_bit: cover property (chg_c && gap_c_r == HALF_CYC);
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench joining host and sensor ends over the supply link.
// Assumes: Responses arrive in request order, one request in flight.
// Notes:   A second sensor on its own link sees short random pulses only.
`timescale 1ns/1ps
module tb_top;
  import link_pkg::*;
  // ==========================================================================
  // Clock, reset and both links
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  req_valid = 1'b0;
  logic [FRAME_BITS-1:0] req_frame = 16'h0000;
  logic [DATA_W-1:0]     angle_in = 12'h000;
  logic                  req_ready, rsp_valid, rsp_ack, prog_mode, cfg_frozen, prog_b;
  logic [FRAME_BITS-1:0] rsp_frame;
  logic [32:0]           exp_q[$];
  int                    err_count = 0;
  int                    total_checks = 0;
  int                    seed = 54826;
  supply_link_if lnk ();
  supply_link_if bad ();
  always #2 mclk = ~mclk;

  host_prog_end host_prog_end_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.host), .req_valid(req_valid),
    .req_frame(req_frame), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_frame(rsp_frame), .rsp_ack(rsp_ack));
  sensor_prog_end sensor_prog_end_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.sensor), .angle_in(angle_in),
    .prog_mode(prog_mode), .cfg_frozen(cfg_frozen));
  sensor_prog_end sensor_prog_end_inst2 (.mclk(mclk), .rst_n(rst_n), .link(bad.sensor), .angle_in(angle_in),
    .prog_mode(prog_b), .cfg_frozen());
  link_monitor link_monitor_inst (.mclk(mclk), .rst_n(rst_n), .sup_hi(lnk.sup_hi), .cur_hi(lnk.cur_hi),
    .prog_mode(prog_mode), .cfg_frozen(cfg_frozen));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The mask hides reply fields the bench does not predict, such as the argument an ACK echoes.
  task automatic send(input logic [15:0] f, input logic [15:0] e, input logic [15:0] m);
    @(posedge mclk);
    #1 exp_q.push_back({e[15:12] != RSP_ERR, e, m});
    req_frame = f;
    req_valid = 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
  endtask

  task automatic wait_idle();
    do @(posedge mclk); while (req_ready !== 1'b1);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Response watcher
  always @(posedge mclk) begin
    logic [32:0] x;
    if (rsp_valid === 1'b1) begin
      chk(16'(exp_q.size() > 0), 16'h0001);
      x = exp_q.pop_front();
      chk(rsp_frame & x[15:0], x[31:16] & x[15:0]);
      chk(16'(rsp_ack), 16'(x[32]));
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [3:0] a;
    logic [7:0] v;
    bad.sup_hi = 1'b0;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(16'({prog_mode, cfg_frozen}), 16'h0000);
    repeat (3000) begin
      @(posedge mclk);
      #1 bad.sup_hi = 1'($random(seed));
    end
    bad.sup_hi = 1'b0;
    chk(16'(prog_b), 16'h0000);
    angle_in = 12'($random(seed));
    send({CMD_ANGLE, DATA_ZERO}, {RSP_DATA, angle_in}, 16'hffff);
    // Entry needs the whole sync pulse, so the mode is looked at once the reply is in.
    wait_idle();
    chk(16'(prog_mode), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      a = 4'($random(seed));
      v = 8'($random(seed));
      send({CMD_WRITE, a, v}, {RSP_ACK, DATA_ZERO}, 16'hf000);
      send({CMD_READ, 8'h00, a}, {RSP_DATA, 4'h0, v}, 16'hf0ff);
    end
    send({CMD_STATUS, DATA_ZERO}, {RSP_DATA, DATA_ZERO}, 16'hffff);
    send({CMD_STORE, DATA_ZERO}, {RSP_ACK, DATA_ZERO}, 16'hf000);
    send({4'h7, DATA_ZERO}, {RSP_ERR, ERR_CMD}, 16'hffff);
    send({CMD_LOCK, DATA_ZERO}, {RSP_ACK, DATA_ZERO}, 16'hf000);
    wait_idle();
    chk(16'(cfg_frozen), 16'h0001);
    send({CMD_STATUS, DATA_ZERO}, {RSP_DATA, 12'h001}, 16'hffff);
    send({CMD_WRITE, a, ~v}, {RSP_ERR, ERR_LOCKED}, 16'hffff);
    send({CMD_STORE, DATA_ZERO}, {RSP_ERR, ERR_LOCKED}, 16'hffff);
    send({CMD_READ, 8'h00, a}, {RSP_DATA, 4'h0, v}, 16'hf0ff);
    wait_idle();
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end

  // Fifteen transfers of about 4000 cycles each fit well inside this span.
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule
